// file: scpi_cfg.svh
// Offsets, reset values and timing counts of the loader
`ifndef SCPI_CFG_SVH
`define SCPI_CFG_SVH

// Clock rate of pclk
`define SCPI_PCLK_MHZ        20
// Register byte offsets
`define SCPI_CTRL_OFS        12'h000
`define SCPI_LEN_OFS         12'h004
`define SCPI_STAT_OFS        12'h008
// Reset values
`define SCPI_CTRL_RST        7'h00
`define SCPI_LEN_RST         24'h000100
// Image layout: 32-bit header, payload of LEN bits, one parity beat
`define SCPI_HDR_BITS        26'h0000020
`define SCPI_SYNC_WORD       16'ha55a
`define SCPI_HDR_INIT_BIT    15
`define SCPI_HDR_PIN_HI      14
`define SCPI_HDR_PIN_LO      13
// Flash read command, arbitrary defaults
`define SCPI_FLASH_RD_X1     8'h03
`define SCPI_FLASH_RD_X4     8'h6b
`define SCPI_FLASH_START     24'h000000
`define SCPI_CMD_BITS        6'h20
// Timing figures and pclk counts
`define SCPI_TCF2ST0_NS      600
`define SCPI_TCF2ST0_CYC     (`SCPI_TCF2ST0_NS * `SCPI_PCLK_MHZ / 1000)
`define SCPI_TSTATUS_MIN_US  268
`define SCPI_TSTATUS_MIN_CYC (`SCPI_TSTATUS_MIN_US * `SCPI_PCLK_MHZ)
`define SCPI_TSTATUS_MAX_US  1506
`define SCPI_TSTATUS_MAX_CYC (`SCPI_TSTATUS_MAX_US * `SCPI_PCLK_MHZ)
`define SCPI_CD2UM_MIN_US    175
`define SCPI_CD2UM_MIN_CYC   (`SCPI_CD2UM_MIN_US * `SCPI_PCLK_MHZ)
`define SCPI_CD2UM_MAX_US    437
`define SCPI_CD2UM_MAX_CYC   (`SCPI_CD2UM_MAX_US * `SCPI_PCLK_MHZ)
`define SCPI_INIT_EDGES      8576
`define SCPI_POR_CYC         64
// Falls before init, half ticks before the switch
`define SCPI_DONE_FALLS      2'h2
`define SCPI_CD2CU_HALVES    4'h8

`endif

// file: scpi_pkg.sv
// Types shared by the serial configuration loader
package scpi_pkg;

   // Loader sequence states
   typedef enum logic [3:0] {
      ST_POR    = 4'h0,
      ST_CLEAR  = 4'h1,
      ST_WAIT   = 4'h2,
      ST_LOAD   = 4'h3,
      ST_EDGES  = 4'h4,
      ST_SWITCH = 4'h5,
      ST_INIT   = 4'h6,
      ST_USER   = 4'h7,
      ST_ERROR  = 4'h8
   } scpi_state_t;

   // Initialization clock source codes
   typedef enum logic [1:0] {
      SRC_OSC  = 2'h0,
      SRC_USER = 2'h1,
      SRC_CFG  = 2'h2,
      SRC_RSVD = 2'h3
   } scpi_src_t;

   // Control register fields, bit 6 first
   typedef struct packed {
      scpi_src_t  init_src;   // Bits 6:5
      logic       chained;    // Bit 4
      logic [1:0] speed;      // Bits 3:2
      logic       quad;       // Bit 1
      logic       active;     // Bit 0
   } scpi_ctrl_t;

   // Options carried in the image header
   typedef struct packed {
      logic       valid;
      logic       init_pin_en;
      logic [1:0] pin_mode;
   } scpi_opt_t;

endpackage : scpi_pkg

// file: scpi_sync.sv
// Two flip-flop synchroniser, one per bit
`timescale 1ns/10ps
module scpi_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Asynchronous in, synchronised out
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta;   // First stage, read only by the second

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         // Each bit gets its own pair of flops
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta[i] <= 1'b0;
               dout[i] <= 1'b0;
            end else begin
               meta[i] <= din[i];
               dout[i] <= meta[i];
            end
         end
      end
   endgenerate

endmodule : scpi_sync

// file: scpi_tick.sv
// Enable pulse divider: one pulse every half cycles of clk
`timescale 1ns/10ps
module scpi_tick #(
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Control
   input  wire logic         en,
   input  wire logic [W-1:0] half,
   // Pulse out
   output logic              tick
);

   logic [W-1:0] cnt;   // Cycles since last pulse

   // Restarts whenever disabled so the first pulse is a full interval away
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt  <= '0;
         tick <= 1'b0;
      end else if (!en) begin
         cnt  <= '0;
         tick <= 1'b0;
      end else if (cnt == half - W'(1)) begin
         cnt  <= '0;
         tick <= 1'b1;
      end else begin
         cnt  <= cnt + W'(1);
         tick <= 1'b0;
      end
   end

endmodule : scpi_tick

// file: scpi_top.sv
// Serial configuration port loader with APB control
//
// Overview of operation
// - Reconfig request falling aborts user mode, restarts
// - User mode keeps request, status, done high
// - Status held low for power-on delay
// - Done stays low until image fully accepted
// - Done released only after error-free image
// - Enabled init pin held low until init ends
// - Data pin becomes user pin per option
// - Quad active mode takes four bits per clock
// - User clock init lasts at least 8576 cycles
// - Status low 268 to 1506 us, extendable externally
// - Status and done low within 600 ns
// - Passive data sampled on config clock rising
// - Active mode launches and captures on falling
// - Active clock has four selectable speed ranges
// - Chained active mode never uses fastest range
// - Init source oscillator, user clock or config
// - Oscillator init ends 175 to 437 us after
// - User clock taken four clock periods after done
`timescale 1ns/10ps
`include "scpi_cfg.svh"
module scpi_top #(
   parameter int POR_CYC        = `SCPI_POR_CYC,
   parameter int STATUS_MIN_CYC = `SCPI_TSTATUS_MIN_CYC,
   parameter int INIT_OSC_CYC   = `SCPI_CD2UM_MIN_CYC,
   parameter int INIT_EDGES     = `SCPI_INIT_EDGES
) (
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Handshake pins, open drain
   input  wire logic        reconfig_req_n,
   input  wire logic        status_n_in,
   output logic             status_n_out,
   output logic             status_n_oe,
   output logic             conf_done_out,
   output logic             conf_done_oe,
   output logic             init_done_n_out,
   output logic             init_done_n_oe,
   // Config clock and serial data
   input  wire logic        config_clock_in,
   output logic             config_clock_out,
   output logic             config_clock_oe,
   input  wire logic        serial_config_data_in,
   output logic             serial_config_data_out,
   output logic             serial_config_data_oe,
   // Flash side
   input  wire logic [3:0]  flash_data_lines,
   output logic             flash_serial_out,
   output logic             flash_select_n,
   // Start-up clock and user side
   input  wire logic        user_startup_clock,
   input  wire logic        user_data_out,
   output logic             user_data_in,
   output logic             user_mode
);

   // Synchronised pins
   logic [8:0]              pin_s;
   logic                    rq_s, st_s, ck_s, sd_s, uc_s;
   logic [3:0]              fd_s;
   logic                    rq_d, ck_d, uc_d;   // Edge history
   logic                    ck_rise, ck_fall, uc_rise, rq_fall;
   // Registers
   scpi_pkg::scpi_ctrl_t    ctrl;
   logic [23:0]             len;
   scpi_pkg::scpi_opt_t     opt;
   scpi_pkg::scpi_state_t   state;
   logic                    img_err;             // Sticky corrupt flag
   // Datapath
   logic [15:0]             tmr;                 // Shared wait counter
   logic [25:0]             bitcnt;              // Image bits taken
   logic [31:0]             hdr;                 // Header shift
   logic                    par;                 // Payload parity
   logic [1:0]              falls;               // Falls after done
   // Active mode clock
   logic                    as_mode, as_run, as_clk, as_tick, as_fall;
   logic [1:0]              eff_speed;
   logic [3:0]              half;
   logic [5:0]              cmd_cnt;
   logic [31:0]             cmd;
   // Beat decode
   logic                    beat;
   logic [3:0]              nib;
   logic [2:0]              bw;
   logic [25:0]             next_bitcnt;
   logic [31:0]             next_hdr;
   logic                    apb_setup, apb_wr;

   // All pins that enter the pclk domain, bar user_data_out, pass two flops
   scpi_sync #(.W(9)) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .din   ({reconfig_req_n, status_n_in, config_clock_in,
               serial_config_data_in, user_startup_clock,
               flash_data_lines}),
      .dout  (pin_s)
   );
   assign {rq_s, st_s, ck_s, sd_s, uc_s, fd_s} = pin_s;

   // Edge history on synchronised copies only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rq_d <= 1'b1;
         ck_d <= 1'b0;
         uc_d <= 1'b0;
      end else begin
         rq_d <= rq_s;
         ck_d <= ck_s;
         uc_d <= uc_s;
      end
   end
   assign rq_fall = rq_d & ~rq_s;
   assign ck_rise = ck_s & ~ck_d;
   assign ck_fall = ~ck_s & ck_d;
   assign uc_rise = uc_s & ~uc_d;

   // Speed range; the fastest code is barred when chained
   always_comb begin
      eff_speed = ctrl.speed;
      if (ctrl.chained && ctrl.speed == 2'h3) begin
         eff_speed = 2'h2;
      end
      // Ranges keep the 1:2:4:8 ratio of the four maximums
      unique case (eff_speed)
         2'h0: half = 4'h8;
         2'h1: half = 4'h4;
         2'h2: half = 4'h2;
         2'h3: half = 4'h1;
      endcase
   end

   assign as_mode = ctrl.active;
   assign as_run  = as_mode && (state == scpi_pkg::ST_LOAD ||
                                state == scpi_pkg::ST_EDGES);

   // Half periods; also pace the clock switch
   scpi_tick #(.W(4)) u_tick (
      .clk   (pclk),
      .rst_n (presetn),
      .en    (1'b1),
      .half  (half),
      .tick  (as_tick)
   );
   assign as_fall = as_run & as_tick & as_clk;

   // Active clock idles high: first edge launches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         as_clk <= 1'b1;
      end else if (!as_run) begin
         as_clk <= 1'b1;
      end else if (as_tick) begin
         as_clk <= ~as_clk;
      end
   end

   // Read command shifted out on falling edges
   assign cmd = {(ctrl.quad ? `SCPI_FLASH_RD_X4 : `SCPI_FLASH_RD_X1),
                 `SCPI_FLASH_START};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_cnt          <= '0;
         flash_serial_out <= 1'b0;
      end else if (state != scpi_pkg::ST_LOAD) begin
         cmd_cnt          <= '0;
         flash_serial_out <= 1'b0;
      end else if (as_fall && cmd_cnt != `SCPI_CMD_BITS) begin
         flash_serial_out <= cmd[5'h1f - cmd_cnt[4:0]];
         cmd_cnt          <= cmd_cnt + 6'h01;
      end
   end

   // Beat: passive rise, or active fall after the command
   always_comb begin
      if (as_mode) begin
         beat = as_fall && cmd_cnt == `SCPI_CMD_BITS;
         // Quad takes all four lines, single takes the return line
         nib  = ctrl.quad ? fd_s : {fd_s[1], 3'h0};
         bw   = ctrl.quad ? 3'h4 : 3'h1;
      end else begin
         beat = ck_rise;
         nib  = {sd_s, 3'h0};
         bw   = 3'h1;
      end
      next_bitcnt = bitcnt + {23'h000000, bw};
      next_hdr    = (bw == 3'h4) ? {hdr[27:0], nib} : {hdr[30:0], nib[3]};
   end

   // Main sequence, one shared wait counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= scpi_pkg::ST_POR;
         tmr     <= '0;
         bitcnt  <= '0;
         hdr     <= '0;
         par     <= 1'b0;
         falls   <= '0;
         opt     <= '0;
         img_err <= 1'b0;
      end else if (rq_fall && state != scpi_pkg::ST_POR) begin
         state   <= scpi_pkg::ST_CLEAR;
         tmr     <= '0;
         opt     <= '0;
         img_err <= 1'b0;
      end else begin
         unique case (state)
            scpi_pkg::ST_POR: begin
               // Status low for the power-on delay
               tmr <= tmr + 16'h0001;
               if (tmr == 16'(POR_CYC - 1)) begin
                  tmr   <= '0;
                  state <= rq_s ? scpi_pkg::ST_WAIT : scpi_pkg::ST_CLEAR;
               end
            end
            scpi_pkg::ST_CLEAR: begin
               // Minimum low time, stretched by a held request
               if (tmr != 16'(STATUS_MIN_CYC - 1)) begin
                  tmr <= tmr + 16'h0001;
               end else if (rq_s) begin
                  state <= scpi_pkg::ST_WAIT;
               end
            end
            scpi_pkg::ST_WAIT: begin
               // Status released; a party holding it low delays us
               bitcnt <= '0;
               par    <= 1'b0;
               falls  <= '0;
               if (st_s) begin
                  state <= scpi_pkg::ST_LOAD;
               end
            end
            scpi_pkg::ST_LOAD: begin
               if (beat) begin
                  bitcnt <= next_bitcnt;
                  if (bitcnt < `SCPI_HDR_BITS) begin
                     hdr <= next_hdr;
                     if (next_bitcnt == `SCPI_HDR_BITS) begin
                        // Header carries sync word and option bits
                        if (next_hdr[31:16] != `SCPI_SYNC_WORD) begin
                           img_err <= 1'b1;
                           state   <= scpi_pkg::ST_ERROR;
                        end
                        opt <= {1'b1, next_hdr[`SCPI_HDR_INIT_BIT],
                                next_hdr[`SCPI_HDR_PIN_HI:`SCPI_HDR_PIN_LO]};
                     end
                  end else if (bitcnt < `SCPI_HDR_BITS + {2'h0, len}) begin
                     par <= par ^ (^nib);
                  end else if (nib[3] == par) begin
                     state <= scpi_pkg::ST_EDGES;
                  end else begin
                     img_err <= 1'b1;
                     state   <= scpi_pkg::ST_ERROR;
                  end
               end
            end
            scpi_pkg::ST_EDGES: begin
               // Two falls after done; active mode makes its own
               if (as_mode ? as_fall : ck_fall) begin
                  falls <= falls + 2'h1;
                  if (falls == `SCPI_DONE_FALLS - 2'h1) begin
                     tmr   <= '0;
                     state <= (ctrl.init_src == scpi_pkg::SRC_USER)
                              ? scpi_pkg::ST_SWITCH : scpi_pkg::ST_INIT;
                  end
               end
            end
            scpi_pkg::ST_SWITCH: begin
               // Wait four active clock periods at the set speed before the swap
               if (as_tick) begin
                  tmr <= tmr + 16'h0001;
                  if (tmr == 16'({12'h000, `SCPI_CD2CU_HALVES}) - 16'h1) begin
                     tmr   <= '0;
                     state <= scpi_pkg::ST_INIT;
                  end
               end
            end
            scpi_pkg::ST_INIT: begin
               // Source choice; config clock only for passive loads
               if (ctrl.init_src == scpi_pkg::SRC_USER) begin
                  if (uc_rise) begin
                     tmr <= tmr + 16'h0001;
                  end
                  if (tmr == 16'(INIT_EDGES)) begin
                     state <= scpi_pkg::ST_USER;
                  end
               end else if (ctrl.init_src == scpi_pkg::SRC_CFG &&
                            !as_mode) begin
                  if (ck_rise) begin
                     tmr <= tmr + 16'h0001;
                  end
                  if (tmr == 16'(INIT_EDGES)) begin
                     state <= scpi_pkg::ST_USER;
                  end
               end else begin
                  tmr <= tmr + 16'h0001;
                  if (tmr == 16'(INIT_OSC_CYC - 1)) begin
                     state <= scpi_pkg::ST_USER;
                  end
               end
            end
            scpi_pkg::ST_USER: begin
               tmr <= '0;   // Only a request edge leaves user mode
            end
            scpi_pkg::ST_ERROR: begin
               tmr <= '0;   // Held until the host requests a restart
            end
            default: begin
               state <= scpi_pkg::ST_CLEAR;
            end
         endcase
      end
   end

   // Pin drivers, all registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_n_oe            <= 1'b1;
         status_n_out           <= 1'b0;
         conf_done_oe           <= 1'b1;
         conf_done_out          <= 1'b0;
         init_done_n_oe         <= 1'b0;
         init_done_n_out        <= 1'b0;
         config_clock_oe        <= 1'b0;
         config_clock_out       <= 1'b1;
         flash_select_n         <= 1'b1;
         serial_config_data_oe  <= 1'b0;
         serial_config_data_out <= 1'b0;
         user_data_in           <= 1'b0;
         user_mode              <= 1'b0;
      end else begin
         // Status low in reset phases and on a bad image
         status_n_oe  <= state == scpi_pkg::ST_POR ||
                         state == scpi_pkg::ST_CLEAR ||
                         state == scpi_pkg::ST_ERROR;
         status_n_out <= 1'b0;
         // Done held low until the image is
         conf_done_oe  <= state == scpi_pkg::ST_POR ||
                          state == scpi_pkg::ST_CLEAR ||
                          state == scpi_pkg::ST_WAIT ||
                          state == scpi_pkg::ST_LOAD ||
                          state == scpi_pkg::ST_ERROR;
         conf_done_out <= 1'b0;
         // Init pin low once its option is loaded, until user mode
         init_done_n_oe  <= opt.valid && opt.init_pin_en &&
                            state != scpi_pkg::ST_USER &&
                            state != scpi_pkg::ST_ERROR;
         init_done_n_out <= 1'b0;
         config_clock_oe  <= as_run;
         config_clock_out <= as_clk;
         flash_select_n   <= !(as_mode && state == scpi_pkg::ST_LOAD);
         // Data pin handed to user logic per option
         serial_config_data_oe  <= state == scpi_pkg::ST_USER &&
                                   opt.pin_mode == 2'h1;
         serial_config_data_out <= user_data_out;
         user_data_in           <= (state == scpi_pkg::ST_USER) & sd_s;
         // All handshake drivers released here
         user_mode <= state == scpi_pkg::ST_USER;
      end
   end

   // APB: no wait states, pready follows the setup cycle
   assign apb_setup = psel & ~penable & ~pready;
   assign apb_wr    = psel & penable & pready & pwrite;

   // Bus answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= apb_setup;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (apb_setup) begin
            unique case (paddr)
               `SCPI_CTRL_OFS: prdata <= {25'h0000000, ctrl};
               `SCPI_LEN_OFS:  prdata <= {8'h00, len};
               `SCPI_STAT_OFS: prdata <= {22'h000000, st_s, img_err,
                                          opt.valid, user_mode,
                                          ~conf_done_oe, 1'b0, state};
               default:        pslverr <= 1'b1;   // Unmapped address
            endcase
         end
      end
   end

   // Writable registers, taken at the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `SCPI_CTRL_RST;
         len  <= `SCPI_LEN_RST;
      end else if (apb_wr) begin
         if (paddr == `SCPI_CTRL_OFS) begin
            ctrl <= pwdata[6:0];
         end
         if (paddr == `SCPI_LEN_OFS) begin
            len <= pwdata[23:0];
         end
      end
   end

endmodule : scpi_top

// file: scpi_monitor.sv
// Checker of the loader pin handshake and APB timing
`timescale 1ns/10ps
module scpi_monitor #(
   parameter int POR_CYC        = 8,
   parameter int STATUS_MIN_CYC = 20
) (
   // Clock, reset and APB handshake
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // Handshake and user pins
   input wire logic reconfig_req_n,
   input wire logic status_n_oe,
   input wire logic conf_done_oe,
   input wire logic init_done_n_oe,
   input wire logic serial_config_data_oe,
   input wire logic user_mode
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [3:0]  por_cnt;  // Cycles since reset, saturating
   logic [15:0] low_cnt;  // Cycles status pulled low
   logic        by_req;   // Pull-down caused by a request
   // Saturates, never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_cnt <= 4'h0;
      end else if (por_cnt != 4'hf) begin
         por_cnt <= por_cnt + 4'h1;
      end
   end
   // Pull-down length and its cause
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt <= 16'h0000;
         by_req  <= 1'b0;
      end else begin
         low_cnt <= status_n_oe ? low_cnt + 16'h0001 : 16'h0000;
         by_req  <= !reconfig_req_n | (by_req & status_n_oe);
      end
   end
   por_hold_a: assert property (por_cnt < POR_CYC |-> status_n_oe)
      else $error("early status");
   req_pull_a: assert property ($fell(reconfig_req_n) |->
      ##[0:12] (status_n_oe && conf_done_oe)) else $error("late pull");
   req_hold_a: assert property ((!reconfig_req_n)[*5] |->
      status_n_oe && !user_mode) else $error("request not obeyed");
   stat_min_a: assert property ($fell(status_n_oe) && by_req |->
      low_cnt >= STATUS_MIN_CYC - 2) else $error("status pulse short");
   user_high_a: assert property (user_mode |->
      !status_n_oe && !conf_done_oe) else $error("pin low in user mode");
   init_end_a: assert property (user_mode |-> !init_done_n_oe)
      else $error("init pin low");
   done_ok_a: assert property ($fell(conf_done_oe) |-> !status_n_oe)
      else $error("done with status low");
   done_first_a: assert property ($rose(user_mode) |->
      $past(!conf_done_oe, 2)) else $error("user mode before done");
   pin_user_a: assert property (serial_config_data_oe |-> user_mode)
      else $error("early data drive");
   apb_ready_a: assert property (pready |->
      penable && $past(psel && !penable)) else $error("stray pready");
   cover property ($rose(user_mode));
   cover property ($fell(status_n_oe) && by_req);
   cover property ($rose(status_n_oe) && reconfig_req_n);
endmodule : scpi_monitor

bind scpi_top scpi_monitor #(.POR_CYC(POR_CYC),
   .STATUS_MIN_CYC(STATUS_MIN_CYC)) scpi_monitor_inst (.*);

// file: scpi_host.sv
// Passive serial host model: config clock and data, MSB first
`timescale 1ns/10ps
module scpi_host (
   // Frame request from the bench
   input  wire logic        go,
   input  wire logic [63:0] img,
   input  wire logic [6:0]  nbits,
   // Pins
   input  wire logic        status_n,
   output logic             config_clock,
   output logic             dat,
   output logic             busy
);
   int i;  // Bit index
   // Clock stands low outside frames
   initial begin
      config_clock = 1'b0;
      dat = 1'b0;
      busy = 1'b0;
   end
   // One frame per request
   always @(posedge go) begin
      busy = 1'b1;
      wait (status_n === 1'b1);
      #2000;
      for (i = nbits - 1; i >= 0; i--) begin
         dat = img[i]; // Stable 200 ns around the rise
         #200 config_clock = 1'b1;
         #200 config_clock = 1'b0;
      end
      dat = ~dat; // Released line must not show the last bit
      repeat (3) begin // Three spare falls
         #200 config_clock = 1'b1;
         #200 config_clock = 1'b0;
      end
      busy = 1'b0;
   end
endmodule : scpi_host

// file: scpi_top_test.sv
// Bench of the serial configuration loader
`timescale 1ns/10ps
`include "scpi_cfg.svh"
module scpi_top_test;
   localparam int ST_MIN = 60;  // Shortened status pulse
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        reconfig_req_n, user_startup_clock, user_data_out, go;
   logic        status_n_oe, conf_done_oe, init_done_n_oe, user_mode;
   logic        serial_config_data_out, serial_config_data_oe, pin;
   logic        user_data_in, hclk, hdat, busy, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [63:0] img;
   int          n_fail, n_compared;
   // Data wire: device in user mode, else host
   assign pin = serial_config_data_oe ? serial_config_data_out : hdat;
   scpi_top #(.POR_CYC(8), .STATUS_MIN_CYC(ST_MIN), .INIT_OSC_CYC(20),
      .INIT_EDGES(16)) scpi_top_inst (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .reconfig_req_n, .status_n_in(~status_n_oe), .status_n_out(),
      .status_n_oe, .conf_done_out(), .conf_done_oe, .init_done_n_out(),
      .init_done_n_oe, .config_clock_in(hclk), .config_clock_out(),
      .config_clock_oe(), .serial_config_data_in(pin),
      .serial_config_data_out, .serial_config_data_oe,
      .flash_data_lines(4'h0), .flash_serial_out(), .flash_select_n(),
      .user_startup_clock, .user_data_out, .user_data_in, .user_mode);
   scpi_host scpi_host_inst (.go, .img, .nbits(7'h29),
      .status_n(~status_n_oe), .config_clock(hclk), .dat(hdat), .busy);
   // Clocks: pclk 50 ns, user clock unrelated at 70 ns
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      user_startup_clock = 1'b0;
      forever #35 user_startup_clock = ~user_startup_clock;
   end
   task chk(input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x) begin
         n_fail++;
         $display("BAD %0t seen %h want %h", $time, s, x);
      end
   endtask : chk
   task conclude;
      if (n_fail == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   // APB transfer, answer taken at the edge that sees pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask : apb
   // Reset values, unmapped address, write and read back
   task t_regs;
      apb(1'b0, `SCPI_CTRL_OFS, 32'h0);
      chk(rd, {25'h0, `SCPI_CTRL_RST});
      apb(1'b0, `SCPI_LEN_OFS, 32'h0);
      chk(rd, {8'h00, `SCPI_LEN_RST});
      apb(1'b1, 12'h00c, 32'hffffffff);
      chk({rd, er}, 33'h1);
      apb(1'b1, `SCPI_LEN_OFS, 32'h8);
      apb(1'b0, `SCPI_LEN_OFS, 32'h0);
      chk(rd, 32'h8);
   endtask : t_regs
   // Image: 8 payload bits, pin mode 01, init pin on
   task t_load(input logic bad, input logic usr);
      time t0;
      img <= {23'h0, `SCPI_SYNC_WORD, 16'ha000, 8'h5b, ^8'h5b ^ bad};
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      if (bad) begin
         wait (busy === 1'b0);
         repeat (8) @(negedge pclk);
         chk(status_n_oe, 1'b1);
         chk(conf_done_oe, 1'b1);
      end else begin
         wait (conf_done_oe === 1'b0);
         t0 = $time;
         wait (user_mode === 1'b1);
         chk($time - t0 >= (usr ? 1120 : 1000), 1'b1);
         @(posedge pclk);
         user_data_out <= 1'b1;
         repeat (5) @(negedge pclk);
         chk(init_done_n_oe, 1'b0);
         chk(serial_config_data_oe, 1'b1);
         chk(user_data_in, 1'b1);
      end
   endtask : t_load
   // 2 us request; pull-down at 575 ns and its length
   task t_reconf;
      int n;
      @(posedge pclk);
      reconfig_req_n <= 1'b0;
      repeat (11) @(posedge pclk);
      @(negedge pclk);
      chk({status_n_oe, conf_done_oe, user_mode}, 3'h6);
      repeat (28) @(posedge pclk);
      reconfig_req_n <= 1'b1;
      n = 40;
      while (status_n_oe === 1'b1) begin
         @(negedge pclk);
         n++;
      end
      chk(n >= ST_MIN, 1'b1);
   endtask : t_reconf
   // Main sequence; reset held for two cycles
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
      {reconfig_req_n, user_data_out, go, img} = {3'h4, 64'h0};
      {n_fail, n_compared} = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_load(1'b0, 1'b0);
      t_reconf;
      t_load(1'b1, 1'b0);
      t_reconf;
      apb(1'b1, `SCPI_CTRL_OFS, 32'h20);
      t_load(1'b0, 1'b1);
      conclude;
   end
   // Watchdog, far past the tests
   initial begin
      #400000;
      n_fail++;
      conclude;
   end
endmodule : scpi_top_test
